// file: core/scss_pkg.sv
// constants, field layouts and carrier types for the system clock source select block
package scss_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int          CLK_HZ            = 25_000_000;  // bus clock rate
    localparam logic [15:0] LXT_STARTUP_TICKS = 16'h0400;    // low crystal start-up, in crystal cycles

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] SCC_OFS   = 8'h00;  // system_clock_control_reg
    localparam logic [7:0] HIRCC_OFS = 8'h04;  // high rc oscillator control
    localparam logic [7:0] HXTC_OFS  = 8'h08;  // high crystal oscillator control
    localparam logic [7:0] LOW_XTAL_CONTROL_REG_OFS  = 8'h0C;  // low_xtal_control_reg
    localparam logic [7:0] STAT_OFS  = 8'h10;  // active clock status, read only

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int SCC_CKS_LSB   = 5;
    localparam int SCC_FHS_BIT   = 3;
    localparam int SCC_FSS_BIT   = 2;
    localparam int SCC_FHIDEN    = 1;
    localparam int SCC_FSIDEN    = 0;
    localparam int HIGH_RC_OSC_FREQ_LSB = 2;
    localparam int OSC_READY_BIT = 1;
    localparam int OSC_EN_BIT    = 0;
    localparam int LXT_SP_BIT    = 2;
    localparam int HXT_MODE_BIT  = 2;

    ////////////////////////////////////////////////////////////////////////////
    // encodings and reset values
    localparam logic [2:0] CKS_FH    = 3'h0;   // undivided high-speed clock
    localparam logic [2:0] CKS_FSUB  = 3'h7;   // low-speed clock
    localparam logic [1:0] HIGH_RC_OSC_4M   = 2'h0;
    localparam logic [1:0] HIGH_RC_OSC_8M   = 2'h1;
    localparam logic [1:0] HIGH_RC_OSC_12M  = 2'h2;
    localparam logic       FHS_HIGH_RC_OSC  = 1'b0;
    localparam logic       FHS_HXT   = 1'b1;
    localparam logic       FSS_LOW_RC_OSC  = 1'b0;
    localparam logic       FSS_LXT   = 1'b1;
    localparam logic       LXT_LOWPWR  = 1'b0;
    localparam logic       LXT_SPEEDUP = 1'b1;

    typedef struct packed {
        logic [2:0] cks;
        logic       high_speed_src_select;
        logic       low_speed_src_select;
        logic       fhiden;
        logic       fsiden;
    } scss_scc_t;

    typedef struct packed {
        logic [2:0] cks;
        logic       high_speed_src_select;
        logic       low_speed_src_select;
    } scss_sel_t;

    localparam scss_scc_t SCC_RST   = '{cks: 3'h0, high_speed_src_select: 1'b0, low_speed_src_select: 1'b0, fhiden: 1'b0, fsiden: 1'b0};
    localparam logic [1:0] HIGH_RC_OSC_RST = 2'h0;

    // mask of high-speed ticks per system tick, minus one; the low-speed code never divides
    function automatic logic [5:0] div_mask(input logic [2:0] cks);
        logic [6:0] m;
        m = 7'h01;
        if (cks != CKS_FSUB) begin
            m = 7'(7'h01 << cks);
        end
        return 6'(m - 7'h01);
    endfunction : div_mask

endpackage : scss_pkg

// file: core/scss_divider.sv
// glitch-free source switch and power-of-two divider for the system clock tick
`timescale 1ns/100ps
`default_nettype none

module scss_divider (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // source ticks
    input  wire logic              hxt_tick_i,
    input  wire logic              high_rc_osc_tick_i,
    input  wire logic              lxt_tick_i,
    input  wire logic              low_rc_osc_tick_i,
    // requested selection
    input  wire scss_pkg::scss_sel_t req_i,
    // results
    output logic                   sys_tick_o,
    output scss_pkg::scss_sel_t    act_o
);

    scss_pkg::scss_sel_t act_q, act_d;
    logic [5:0]          cnt_q, cnt_d;
    logic                tick_q, tick_d;
    logic                fh_tick, fsub_tick, src_tick;

    ////////////////////////////////////////////////////////////////////////////
    // next state: selection only moves at a period boundary, so no short pulse
    always_comb begin
        fh_tick   = (act_q.high_speed_src_select == scss_pkg::FHS_HXT) ? hxt_tick_i : high_rc_osc_tick_i;
        fsub_tick = (act_q.low_speed_src_select == scss_pkg::FSS_LXT) ? lxt_tick_i : low_rc_osc_tick_i;
        src_tick  = (act_q.cks == scss_pkg::CKS_FSUB) ? fsub_tick : fh_tick;
        act_d     = act_q;
        cnt_d     = cnt_q;
        tick_d    = 1'b0;
        if (src_tick) begin
            if (cnt_q == scss_pkg::div_mask(act_q.cks)) begin
                tick_d = 1'b1;
                cnt_d  = 6'h00;
                act_d  = req_i;
            end else begin
                cnt_d = 6'(cnt_q + 6'h01);
            end
        end
    end

    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            act_q  <= '0;
            cnt_q  <= 6'h00;
            tick_q <= 1'b0;
        end else if (ce_i) begin
            act_q  <= act_d;
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign sys_tick_o = tick_q;
    assign act_o      = act_q;

endmodule : scss_divider

`default_nettype wire

// file: core/scss_top.sv
// system clock source select: registers, oscillator control and clock gating
//
// Overview of operation
// - four sources: two fast, two slow
// - fast rc runs at 4, 8 or 12 MHz
// - fast crystal 400kHz-16MHz on own pins
// - slow crystal fixed 32.768kHz on own pins
// - slow rc nominal 32kHz, no parts
// - select field picks fast or slow path
// - source bits pick oscillator per class
// - exactly one oscillator per class always; here enable bits can keep both of a class running, and the slow rc never stops
// - crystal enable, ready flag after start-up
// - halt stops system clock, peripherals optional
// - slow crystal pins free when unused
// - speed-up bit picks crystal mode
// - oscillators also feed watchdog, time base
// - codes 000-110 divide by 2^n, 111 slow
// - speed-up 0 low power, 1 fast start
// - mode locked while slow crystal drives system
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module scss_top (
    // clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic             wb_ack_o,
    output logic [31:0]      wb_dat_o,
    // oscillator ticks, one cycle per oscillator period
    input  wire logic        hxt_tick_i,
    input  wire logic        high_rc_osc_tick_i,
    input  wire logic        lxt_tick_i,
    input  wire logic        low_rc_osc_tick_i,
    // processor halt request
    input  wire logic        halt_i,
    // oscillator controls
    output logic             hxt_en_o,
    output logic             high_rc_osc_en_o,
    output logic [1:0]       high_rc_osc_freq_o,
    output logic             lxt_en_o,
    output logic             lxt_speedup_o,
    output logic             low_xtal_pins_osc_o,
    // clock ticks
    output logic             sys_tick_o,
    output logic             sys_clk_o,
    output logic             fh_tick_o,
    output logic             fsub_tick_o,
    output logic             low_rc_osc_tick_o
);

    ////////////////////////////////////////////////////////////////////////////
    // register state
    scss_pkg::scss_scc_t scc_q, scc_d;
    logic [1:0]          high_rc_osc_freq_q, high_rc_osc_freq_d;
    logic                high_rc_osc_en_q, high_rc_osc_en_d;
    logic                hxt_en_q, hxt_en_d;
    logic                hxt_mode_q, hxt_mode_d;
    logic                lxt_en_q, lxt_en_d;
    logic                lxt_sp_q, lxt_sp_d;
    logic                lxt_rdy_q, lxt_rdy_d;
    logic                high_rc_osc_rdy_q, high_rc_osc_rdy_d;
    logic                hxt_rdy_q, hxt_rdy_d;
    logic [15:0]         lxt_cnt_q, lxt_cnt_d;
    logic                ack_q, ack_d;
    logic [31:0]         rdat_q, rdat_d;
    logic                wr_en;
    logic                lxt_is_sys;
    scss_pkg::scss_sel_t req, act;
    logic                div_tick;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        return adr == ofs;
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////
    // register next values; write lands at the ack edge
    always_comb begin
        wr_en       = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];
        lxt_is_sys  = (act.cks == scss_pkg::CKS_FSUB) && (act.low_speed_src_select == scss_pkg::FSS_LXT);
        scc_d       = scc_q;
        high_rc_osc_freq_d = high_rc_osc_freq_q;
        high_rc_osc_en_d   = high_rc_osc_en_q;
        hxt_en_d    = hxt_en_q;
        hxt_mode_d  = hxt_mode_q;
        lxt_en_d    = lxt_en_q;
        lxt_sp_d    = lxt_sp_q;
        if (wr_en && hit(wb_adr_i, scss_pkg::SCC_OFS)) begin
            scc_d = '{cks:    wb_dat_i[scss_pkg::SCC_CKS_LSB +: 3],
                      high_speed_src_select:    wb_dat_i[scss_pkg::SCC_FHS_BIT],
                      low_speed_src_select:    wb_dat_i[scss_pkg::SCC_FSS_BIT],
                      fhiden: wb_dat_i[scss_pkg::SCC_FHIDEN],
                      fsiden: wb_dat_i[scss_pkg::SCC_FSIDEN]};
        end
        if (wr_en && hit(wb_adr_i, scss_pkg::HIRCC_OFS)) begin
            high_rc_osc_en_d = wb_dat_i[scss_pkg::OSC_EN_BIT];
            // the unused fourth code keeps the present frequency
            if (wb_dat_i[scss_pkg::HIGH_RC_OSC_FREQ_LSB +: 2] != 2'h3) begin
                high_rc_osc_freq_d = wb_dat_i[scss_pkg::HIGH_RC_OSC_FREQ_LSB +: 2];
            end
        end
        if (wr_en && hit(wb_adr_i, scss_pkg::HXTC_OFS)) begin
            hxt_en_d   = wb_dat_i[scss_pkg::OSC_EN_BIT];
            hxt_mode_d = wb_dat_i[scss_pkg::HXT_MODE_BIT];
        end
        if (wr_en && hit(wb_adr_i, scss_pkg::LOW_XTAL_CONTROL_REG_OFS)) begin
            lxt_en_d = wb_dat_i[scss_pkg::OSC_EN_BIT];
            if (!lxt_is_sys) begin
                lxt_sp_d = wb_dat_i[scss_pkg::LXT_SP_BIT];
            end
        end
    end

    // register flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scc_q       <= scss_pkg::SCC_RST;
            high_rc_osc_freq_q <= scss_pkg::HIGH_RC_OSC_RST;
            high_rc_osc_en_q   <= 1'b1;
            hxt_en_q    <= 1'b0;
            hxt_mode_q  <= 1'b0;
            lxt_en_q    <= 1'b0;
            lxt_sp_q    <= scss_pkg::LXT_LOWPWR;
        end else if (ce_i) begin
            scc_q       <= scc_d;
            high_rc_osc_freq_q <= high_rc_osc_freq_d;
            high_rc_osc_en_q   <= high_rc_osc_en_d;
            hxt_en_q    <= hxt_en_d;
            hxt_mode_q  <= hxt_mode_d;
            lxt_en_q    <= lxt_en_d;
            lxt_sp_q    <= lxt_sp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // oscillator ready flags; the slow crystal counts its own cycles to start up
    always_comb begin
        high_rc_osc_rdy_d = high_rc_osc_rdy_q;
        hxt_rdy_d  = hxt_rdy_q;
        lxt_rdy_d  = lxt_rdy_q;
        lxt_cnt_d  = lxt_cnt_q;
        if (!high_rc_osc_en_o) begin
            high_rc_osc_rdy_d = 1'b0;
        end else if (high_rc_osc_tick_i) begin
            high_rc_osc_rdy_d = 1'b1;
        end
        if (!hxt_en_o) begin
            hxt_rdy_d = 1'b0;
        end else if (hxt_tick_i) begin
            hxt_rdy_d = 1'b1;
        end
        if (!lxt_en_o) begin
            lxt_rdy_d = 1'b0;
            lxt_cnt_d = 16'h0000;
        end else if (lxt_tick_i && !lxt_rdy_q) begin
            lxt_cnt_d = 16'(lxt_cnt_q + 16'h0001);
            if (lxt_cnt_d == scss_pkg::LXT_STARTUP_TICKS) begin
                lxt_rdy_d = 1'b1;
            end
        end
    end

    // ready flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            high_rc_osc_rdy_q <= 1'b0;
            hxt_rdy_q  <= 1'b0;
            lxt_rdy_q  <= 1'b0;
            lxt_cnt_q  <= 16'h0000;
        end else if (ce_i) begin
            high_rc_osc_rdy_q <= high_rc_osc_rdy_d;
            hxt_rdy_q  <= hxt_rdy_d;
            lxt_rdy_q  <= lxt_rdy_d;
            lxt_cnt_q  <= lxt_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wishbone: ack one cycle after the strobe, dropped the cycle after
    always_comb begin
        ack_d  = wb_cyc_i & wb_stb_i & ~ack_q;
        rdat_d = 32'h0000_0000;                                   // unmapped reads as zero
        unique case (1'b1)
            hit(wb_adr_i, scss_pkg::SCC_OFS): begin
                rdat_d[7:0] = {scc_q.cks, 1'b0, scc_q.high_speed_src_select, scc_q.low_speed_src_select, scc_q.fhiden, scc_q.fsiden};
            end
            hit(wb_adr_i, scss_pkg::HIRCC_OFS): begin
                rdat_d[3:0] = {high_rc_osc_freq_q, high_rc_osc_rdy_q, high_rc_osc_en_q};
            end
            hit(wb_adr_i, scss_pkg::HXTC_OFS): begin
                rdat_d[2:0] = {hxt_mode_q, hxt_rdy_q, hxt_en_q};
            end
            hit(wb_adr_i, scss_pkg::LOW_XTAL_CONTROL_REG_OFS): begin
                rdat_d[2:0] = {lxt_sp_q, lxt_rdy_q, lxt_en_q};
            end
            hit(wb_adr_i, scss_pkg::STAT_OFS): begin
                rdat_d[5:0] = {act.cks, act.high_speed_src_select, act.low_speed_src_select, halt_i};
            end
            default: begin
                rdat_d = 32'h0000_0000;
            end
        endcase
    end

    // bus flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    ////////////////////////////////////////////////////////////////////////////
    // source switch and divider; the slow crystal only counts once it is ready
    assign req = '{cks: scc_q.cks, high_speed_src_select: scc_q.high_speed_src_select, low_speed_src_select: scc_q.low_speed_src_select};

    scss_divider u_div (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .hxt_tick_i  (hxt_tick_i),
        .high_rc_osc_tick_i (high_rc_osc_tick_i),
        .lxt_tick_i  (lxt_tick_i & lxt_rdy_q),
        .low_rc_osc_tick_i (low_rc_osc_tick_i),
        .req_i       (req),
        .sys_tick_o  (div_tick),
        .act_o       (act)
    );

    ////////////////////////////////////////////////////////////////////////////
    // output stage: gating under halt and oscillator enables
    logic sys_tick_q, sys_clk_q, fh_tick_q, fsub_tick_q, low_rc_osc_tick_q;
    logic hxt_on_q, high_rc_osc_on_q, lxt_on_q, pins_q;
    logic fh_raw, fsub_raw, fh_used;

    always_comb begin
        fh_raw   = (act.high_speed_src_select == scss_pkg::FHS_HXT) ? hxt_tick_i : high_rc_osc_tick_i;
        fsub_raw = (act.low_speed_src_select == scss_pkg::FSS_LXT) ? (lxt_tick_i & lxt_rdy_q) : low_rc_osc_tick_i;
        fh_used  = (act.cks != scss_pkg::CKS_FSUB) | (halt_i & scc_q.fhiden);
    end

    // output flops; the slow rc always runs for the watchdog and time base
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_tick_q  <= 1'b0;
            sys_clk_q   <= 1'b0;
            fh_tick_q   <= 1'b0;
            fsub_tick_q <= 1'b0;
            low_rc_osc_tick_q <= 1'b0;
            hxt_on_q    <= 1'b0;
            high_rc_osc_on_q   <= 1'b1;
            lxt_on_q    <= 1'b0;
            pins_q      <= 1'b0;
        end else if (ce_i) begin
            sys_tick_q  <= div_tick & ~halt_i;
            sys_clk_q   <= sys_clk_q ^ (div_tick & ~halt_i);
            fh_tick_q   <= fh_raw & (~halt_i | scc_q.fhiden);
            fsub_tick_q <= fsub_raw & (~halt_i | scc_q.fsiden);
            low_rc_osc_tick_q <= low_rc_osc_tick_i;
            hxt_on_q    <= hxt_en_q | (fh_used & act.high_speed_src_select == scss_pkg::FHS_HXT);
            high_rc_osc_on_q   <= high_rc_osc_en_q | (fh_used & act.high_speed_src_select == scss_pkg::FHS_HIGH_RC_OSC);
            lxt_on_q    <= lxt_en_q;
            pins_q      <= lxt_en_q | (act.low_speed_src_select == scss_pkg::FSS_LXT);
        end
    end

    assign sys_tick_o          = sys_tick_q;
    assign sys_clk_o           = sys_clk_q;
    assign fh_tick_o           = fh_tick_q;
    assign fsub_tick_o         = fsub_tick_q;
    assign low_rc_osc_tick_o         = low_rc_osc_tick_q;
    assign hxt_en_o            = hxt_on_q;
    assign high_rc_osc_en_o           = high_rc_osc_on_q;
    assign high_rc_osc_freq_o         = high_rc_osc_freq_q;
    assign lxt_en_o            = lxt_on_q;
    assign lxt_speedup_o       = lxt_sp_q;
    assign low_xtal_pins_osc_o = pins_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_halt_stops_sys: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && halt_i) |=> !sys_tick_o) else $error("system tick while halted");

    a_sp_locked: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && lxt_is_sys) |=> $stable(lxt_sp_q)) else $error("speed-up changed while locked");

    a_lxt_rdy_enable: assert property (@(posedge clk_i) disable iff (rst_i)
        lxt_rdy_q |-> $past(lxt_en_o) && lxt_cnt_q == scss_pkg::LXT_STARTUP_TICKS)
        else $error("crystal ready without full start-up");

    a_high_rc_osc_freq_legal: assert property (@(posedge clk_i) disable iff (rst_i)
        high_rc_osc_freq_o != 2'h3) else $error("illegal rc frequency code");

    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && wb_ack_o) |=> !wb_ack_o) else $error("ack held two cycles");

    a_act_at_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !div_tick && $past(ce_i)) |-> $stable(act))
        else $error("selection moved outside a boundary");

    a_pins_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && lxt_en_q) |=> low_xtal_pins_osc_o) else $error("crystal pins not claimed");

    a_low_rc_osc_passes: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && low_rc_osc_tick_i) |=> low_rc_osc_tick_o) else $error("slow rc tick lost");

    a_clk_toggles: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(ce_i) |-> ((sys_clk_o != $past(sys_clk_o)) == sys_tick_o))
        else $error("clock toggle out of step");

endmodule : scss_top

`default_nettype wire

// file: dv/scss_osc_model.sv
// oscillator tick sources standing in for the two crystals and two rc oscillators
`timescale 1ns/100ps
`default_nettype none

module scss_osc_model #(
    parameter int HXT_P  = 3,
    parameter int HIGH_RC_OSC_P = 2,
    parameter int LXT_P  = 4,
    parameter int LOW_RC_OSC_P = 5
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // oscillator enables
    input  wire logic hxt_en_i,
    input  wire logic high_rc_osc_en_i,
    input  wire logic lxt_en_i,
    // ticks, one cycle per oscillator period
    output logic      hxt_tick_o,
    output logic      high_rc_osc_tick_o,
    output logic      lxt_tick_o,
    output logic      low_rc_osc_tick_o
);
    localparam int PER [4] = '{HXT_P, HIGH_RC_OSC_P, LXT_P, LOW_RC_OSC_P};
    logic [3:0] en;
    logic [3:0] tk;
    int         cnt [4];

    // a stopped oscillator gives no ticks at all, so no stale pulse leaks through
    assign en = {1'b1, lxt_en_i, high_rc_osc_en_i, hxt_en_i};
    assign {low_rc_osc_tick_o, lxt_tick_o, high_rc_osc_tick_o, hxt_tick_o} = tk;

    // free-running period counters, one per source
    always @(posedge clk_i) begin
        for (int i = 0; i < 4; i++) begin
            if (rst_i || !en[i]) begin
                cnt[i] <= 0;
                tk[i]  <= 1'b0;
            end else begin
                cnt[i] <= (cnt[i] == PER[i] - 1) ? 0 : cnt[i] + 1;
                tk[i]  <= (cnt[i] == PER[i] - 1);
            end
        end
    end
endmodule : scss_osc_model
`default_nettype wire

// file: dv/test_system_clock_source_select.sv
// self-checking bench for the system clock source select block
`timescale 1ns/100ps
`default_nettype none

module test_system_clock_source_select;
    localparam int HP = 3, RP = 2, LP = 4;
    logic        clk_i = 0, rst_i = 1, ce_i = 1, halt_i = 0;
    logic        cyc = 0, stb = 0, we = 0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, wb_dat_o;
    logic [3:0]  sel = 4'h0;
    logic        wb_ack_o, hxt_en_o, high_rc_osc_en_o, lxt_en_o, lxt_speedup_o, pins_o;
    logic        hxt_t, high_rc_osc_t, lxt_t, low_rc_osc_t, sys_tick_o, fh_tick_o, low_rc_osc_tick_o;
    logic        sys_clk_o, fsub_tick_o;
    logic [1:0]  high_rc_osc_freq_o;
    logic [31:0] exp_q [$];
    int          bad_count = 0, n_compared = 0, cycles = 0, n_sys, n_fh, n_low_rc_osc, k;
    int          c, n_fsub, n_clk;

    ////////////////////////////////////////////////////////////////////////////
    // design and oscillator model
    scss_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o), .hxt_tick_i(hxt_t), .high_rc_osc_tick_i(high_rc_osc_t), .lxt_tick_i(lxt_t),
        .low_rc_osc_tick_i(low_rc_osc_t), .halt_i(halt_i), .hxt_en_o(hxt_en_o), .high_rc_osc_en_o(high_rc_osc_en_o),
        .high_rc_osc_freq_o(high_rc_osc_freq_o), .lxt_en_o(lxt_en_o), .lxt_speedup_o(lxt_speedup_o),
        .low_xtal_pins_osc_o(pins_o), .sys_tick_o(sys_tick_o), .sys_clk_o(sys_clk_o),
        .fh_tick_o(fh_tick_o), .fsub_tick_o(fsub_tick_o), .low_rc_osc_tick_o(low_rc_osc_tick_o));
    scss_osc_model #(.HXT_P(HP), .HIGH_RC_OSC_P(RP), .LXT_P(LP), .LOW_RC_OSC_P(5)) osc_u (.clk_i(clk_i),
        .rst_i(rst_i), .hxt_en_i(hxt_en_o), .high_rc_osc_en_i(high_rc_osc_en_o), .lxt_en_i(lxt_en_o),
        .hxt_tick_o(hxt_t), .high_rc_osc_tick_o(high_rc_osc_t), .lxt_tick_o(lxt_t), .low_rc_osc_tick_o(low_rc_osc_t));

    ////////////////////////////////////////////////////////////////////////////
    // clock, timeout and read-data monitor
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin // ceiling well above the roughly 6000 cycles needed
        cycles++;
        if (cycles > 40000) begin
            bad_count++;
            give_verdict();
        end
    end
    // reads are judged against the oldest note the driver left
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && !we) begin
            if (exp_q.size() == 0) chk("stray read", 32'hFFFF_FFFF, wb_dat_o);
            else chk("read data", exp_q.pop_front(), wb_dat_o);
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one classic cycle; waits for ack at a rising edge, then releases
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 100);
        if (wb_ack_o !== 1'b1) begin
            bad_count++;
            $display("[FAIL] bus ack expected 1 seen %b", wb_ack_o);
        end
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask : rd

    // skips the rest of the current period and one whole period so a pending selection has applied, then times the next
    task automatic meas(input int e);
        int n;
        for (int j = 0; j < 3; j++) begin
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (sys_tick_o !== 1'b1 && n < 2000);
        end
        chk("sys tick period", 32'(e), 32'(n));
    endtask : meas

    task automatic count(input int len);
        logic prev;
        n_sys = 0; n_fh = 0; n_low_rc_osc = 0; n_fsub = 0; n_clk = 0;
        prev = sys_clk_o;
        repeat (len) begin
            @(posedge clk_i);
            n_sys += int'(sys_tick_o === 1'b1);
            n_fh += int'(fh_tick_o === 1'b1);
            n_low_rc_osc += int'(low_rc_osc_tick_o === 1'b1);
            n_fsub += int'(fsub_tick_o === 1'b1);
            n_clk += int'(sys_clk_o !== prev);
            prev = sys_clk_o;
        end
    endtask : count

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(32'hC872));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("enables", 32'h2, {hxt_en_o, high_rc_osc_en_o, lxt_en_o});
        chk("pins", 32'h0, 32'(pins_o));
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h3);
        rd(8'h20, 32'h0);
        wb(1'b1, 8'h20, 32'hFF);
        $display("test reset values done");
        for (int f = 3; f >= 0; f--) begin // code 3 is refused and leaves the value alone
            wb(1'b1, 8'h04, 32'(f << 2) | 32'h1);
            chk("high_rc_osc freq", f == 3 ? 32'h0 : 32'(f), 32'(high_rc_osc_freq_o));
        end
        $display("test rc frequency done");
        for (k = 0; k < 8; k++) begin // last pass takes a random division code
            c = (k == 7) ? int'($urandom % 7) : k;
            wb(1'b1, 8'h00, 32'(c << 5));
            meas(RP << c);
        end
        $display("test divider done");
        wb(1'b1, 8'h00, 32'h08);
        meas(HP);
        chk("hxt enable", 32'h1, 32'(hxt_en_o));
        wb(1'b1, 8'h00, 32'h00);
        $display("test fast crystal done");
        wb(1'b1, 8'h0C, 32'h01);
        chk("speed-up low power", 32'h0, 32'(lxt_speedup_o));
        wb(1'b1, 8'h0C, 32'h05);
        chk("speed-up on", 32'h1, 32'(lxt_speedup_o));
        chk("pins claimed", 32'h1, 32'(pins_o));
        rd(8'h0C, 32'h5);
        repeat (1024 * LP + 40) @(posedge clk_i);
        rd(8'h0C, 32'h7);
        wb(1'b1, 8'h00, 32'hE4);
        meas(LP);
        rd(8'h10, 32'h3A);
        wb(1'b1, 8'h0C, 32'h01);
        chk("mode locked", 32'h1, 32'(lxt_speedup_o));
        $display("test slow crystal done");
        halt_i <= 1'b1;
        @(posedge clk_i); // a tick launched before the halt was seen may still stand
        count(300);
        chk("halted sys ticks", 32'h0, 32'(n_sys));
        chk("halted fast ticks", 32'h0, 32'(n_fh));
        chk("halted slow ticks", 32'h0, 32'(n_fsub));
        chk("low_rc_osc ticks live", 32'h1, 32'(n_low_rc_osc > 0));
        wb(1'b1, 8'h00, 32'hE6);
        count(100);
        chk("idle fast ticks", 32'h1, 32'(n_fh > 0));
        halt_i <= 1'b0;
        count(100);
        chk("sys ticks resume", 32'h1, 32'(n_sys > 0));
        chk("slow ticks resume", 32'h1, 32'(n_fsub > 0));
        chk("sys clk toggles", 32'(n_sys), 32'(n_clk));
        $display("test halt done");
        ce_i <= 1'b0;
        @(posedge clk_i);
        count(20);
        chk("frozen sys clk", 32'h0, 32'(n_clk));
        ce_i <= 1'b1;
        $display("test clock enable done");
        give_verdict();
    end
endmodule : test_system_clock_source_select
`default_nettype wire
